//--- rtl/fsag_pkg.sv
// Package for the fault supervisor and adjust gate: register map, error codes, field layouts.
// Assumes a single 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package fsag_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] FSAG_OFS_STATUS = 8'h00;
  localparam logic [7:0] FSAG_OFS_CTRL = 8'h04;
  localparam logic [7:0] FSAG_OFS_ADJ_SPEED = 8'h08;
  localparam logic [7:0] FSAG_OFS_ADJ_RAMP = 8'h0C;
  localparam logic [7:0] FSAG_OFS_MAX_SPEED = 8'h10;
  localparam logic [7:0] FSAG_OFS_FEEDFORWARD_GAIN = 8'h14;
  localparam logic [7:0] FSAG_OFS_P_GAIN = 8'h18;
  localparam logic [7:0] FSAG_OFS_RATIO_MIN = 8'h1C;
  localparam logic [7:0] FSAG_OFS_RATIO_MAX = 8'h20;
  localparam logic [7:0] FSAG_OFS_CYCLE_MAX = 8'h24;

  // Control register bits
  localparam int FSAG_CTRL_CLEAR = 0;
  localparam int FSAG_CTRL_ADJ_REQ = 1;
  localparam int FSAG_CTRL_ADJ_EXIT = 2;
  localparam int FSAG_CTRL_HOMING_REQ = 3;

  // Status register fields
  localparam int FSAG_ST_CODE_LSB = 0;
  localparam int FSAG_ST_ACTIVE = 8;
  localparam int FSAG_ST_HOLD = 9;
  localparam int FSAG_ST_ADJUST = 10;
  localparam int FSAG_ST_HW_FLAG = 11;

  // Reset values
  localparam logic [15:0] FSAG_RST_FEEDFORWARD_GAIN = 16'h2710;
  localparam logic [15:0] FSAG_RST_P_GAIN = 16'h01F4;
  localparam logic [31:0] FSAG_RST_MAX_SPEED = 32'h0000_2710;
  localparam logic [15:0] FSAG_RST_ADJ_RAMP = 16'h0001;
  localparam logic [15:0] FSAG_RST_RATIO_MIN = 16'h0000;
  localparam logic [15:0] FSAG_RST_RATIO_MAX = 16'hFFFF;
  localparam logic [15:0] FSAG_RST_CYCLE_MAX = 16'h03E8;
  localparam int FSAG_ADJ_SPEED_PCT = 10;
  localparam logic [1:0] FSAG_RESP_OKAY = 2'b00;
  localparam logic [1:0] FSAG_RESP_SLVERR = 2'b10;

  // Error codes
  localparam logic [7:0] FSAG_ERR_HW = 8'h00;
  localparam logic [7:0] FSAG_ERR_PWR_LOW = 8'h01;
  localparam logic [7:0] FSAG_ERR_CUT_NP = 8'h02;
  localparam logic [7:0] FSAG_ERR_LIMIT = 8'h03;
  localparam logic [7:0] FSAG_ERR_MARK_OVF = 8'h04;
  localparam logic [7:0] FSAG_ERR_RATIO = 8'h05;
  localparam logic [7:0] FSAG_ERR_NO_HOME = 8'h06;
  localparam logic [7:0] FSAG_ERR_SEQ = 8'h07;
  localparam logic [7:0] FSAG_ERR_WDOG = 8'h09;
  localparam logic [7:0] FSAG_ERR_SUPPLY0 = 8'h0A;
  localparam logic [7:0] FSAG_ERR_TEMP = 8'h0F;
  localparam logic [7:0] FSAG_ERR_BUS = 8'h1F;
  localparam int FSAG_NUM_SUPPLY = 5;

  typedef enum logic [1:0] {FSAG_RUN, FSAG_CUT_FINISH, FSAG_HOLD} fsag_state_e;

  // Fault inputs from the machine side
  typedef struct packed {
    logic hw_fail;
    logic pwr_low;
    logic cut_not_possible;
    logic rear_limit;
    logic mark_overflow;
    logic seq_bad_state;
    logic bus_fault;
    logic over_temp;
    logic [4:0] supply_bad;
  } fsag_faults_s;

endpackage

//--- rtl/fsag_top.sv
// Fault supervisor and adjust gate of a flying-shear controller.
// Machine inputs are synchronous to CLK_SYS; registers sit on AXI4-Lite.
`timescale 1ns/1ps

// Operation
// - Any detected error except hardware check failure latches error state and drives error output high.
// - In error, finish current cut, then hold both axes at standstill.
// - Clear by command, loop enable low or power cycle, except special codes.
// - After clear, re-enter error at once if cause still present.
// - Hardware check failure: code 00, display only, power cycle clears.
// - Undervoltage: code 01, clears itself when supply recovers.
// - Code 02 when forward move needed before carriage home.
// - Code 03 when rear software limit reached in automatic cutting.
// - Code 04 on print-mark buffer overflow.
// - Encoder ratio error when line to carriage ratio leaves range.
// - Code 06 if cutting starts unhomed while homing is required.
// - Code 07 when sequencer reaches an unexpected state.
// - Code 09 when control cycle overruns allowed time.
// - Codes 10 to 14 for internal supply out of range.
// - Code 15 on over-temperature.
// - Code 31 on fieldbus module fault.
// - Adjust mode entered only while loop enable is low.
// - Adjust mode: carriage always follows simulated line.
// - Adjust mode: simulated speed defaults to 10% of max line speed.
// - Adjust mode: one ramp time for every acceleration and deceleration.
module fsag_top #(
  parameter int RATIO_W = 16
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire fsag_pkg::fsag_faults_s FAULTS,
  input wire logic LOOP_ENABLE,
  input wire logic CUT_ACTIVE,
  input wire logic AUTO_CUTTING,
  input wire logic CUT_START,
  input wire logic HOMED,
  input wire logic CYCLE_START,
  input wire logic LINE_PULSE,
  input wire logic CARR_PULSE,
  input wire logic RATIO_WINDOW,
  input wire logic SIM_LINE_SELECT,
  output logic ERROR_OUT,
  output logic AXIS_HOLD,
  output logic ADJUST_MODE,
  output logic USE_SIM_LINE,
  output logic [31:0] SIM_LINE_SPEED,
  output logic [15:0] ACC_RAMP,
  output logic [15:0] DEC_RAMP,
  output logic [15:0] FEEDFORWARD_GAIN,
  output logic [15:0] P_GAIN
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave

  logic aw_full_reg;
  logic [7:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic clear_cmd;
  logic adj_req;
  logic adj_exit;
  logic homing_req_reg;
  logic [31:0] adj_speed_reg;
  logic adj_speed_set_reg;
  logic [15:0] adj_ramp_reg;
  logic [31:0] max_speed_reg;
  logic [15:0] feedforward_gain_reg;
  logic [15:0] p_gain_reg;
  logic [15:0] ratio_min_reg;
  logic [15:0] ratio_max_reg;
  logic [15:0] cycle_max_reg;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Byte-lane merge for the 16-bit registers that sit in the low half of a word
  function automatic logic [15:0] merge_lo(input logic [15:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = merge({16'h0000, old}, nw, strb);
    return r[15:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= fsag_pkg::FSAG_OFS_CYCLE_MAX);
  endfunction

  assign wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID;
  assign wr_hit = wr_fire && mapped(aw_addr_reg);
  assign clear_cmd = wr_hit && aw_addr_reg == fsag_pkg::FSAG_OFS_CTRL && w_strb_reg[0]
                     && w_data_reg[fsag_pkg::FSAG_CTRL_CLEAR];
  assign adj_req = wr_hit && aw_addr_reg == fsag_pkg::FSAG_OFS_CTRL && w_strb_reg[0]
                   && w_data_reg[fsag_pkg::FSAG_CTRL_ADJ_REQ];
  assign adj_exit = wr_hit && aw_addr_reg == fsag_pkg::FSAG_OFS_CTRL && w_strb_reg[0]
                    && w_data_reg[fsag_pkg::FSAG_CTRL_ADJ_EXIT];

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      S_AXI_AWREADY <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_full_reg && !S_AXI_AWREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR[7:0];
        S_AXI_AWREADY <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      S_AXI_WREADY <= !w_full_reg && !S_AXI_WREADY;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= fsag_pkg::FSAG_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= mapped(aw_addr_reg) ? fsag_pkg::FSAG_RESP_OKAY
                                         : fsag_pkg::FSAG_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Configuration registers; gains reset to the recommended start values
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      homing_req_reg <= 1'b0;
      adj_speed_reg <= 32'h0000_0000;
      adj_speed_set_reg <= 1'b0;
      adj_ramp_reg <= fsag_pkg::FSAG_RST_ADJ_RAMP;
      max_speed_reg <= fsag_pkg::FSAG_RST_MAX_SPEED;
      feedforward_gain_reg <= fsag_pkg::FSAG_RST_FEEDFORWARD_GAIN;
      p_gain_reg <= fsag_pkg::FSAG_RST_P_GAIN;
      ratio_min_reg <= fsag_pkg::FSAG_RST_RATIO_MIN;
      ratio_max_reg <= fsag_pkg::FSAG_RST_RATIO_MAX;
      cycle_max_reg <= fsag_pkg::FSAG_RST_CYCLE_MAX;
    end
    else if (wr_hit)
    begin
      case (aw_addr_reg)
        fsag_pkg::FSAG_OFS_CTRL:
          if (w_strb_reg[0])
          begin
            homing_req_reg <= w_data_reg[fsag_pkg::FSAG_CTRL_HOMING_REQ];
          end
        fsag_pkg::FSAG_OFS_ADJ_SPEED:
        begin
          adj_speed_reg <= merge(adj_speed_reg, w_data_reg, w_strb_reg);
          adj_speed_set_reg <= 1'b1;
        end
        fsag_pkg::FSAG_OFS_ADJ_RAMP:
          adj_ramp_reg <= merge_lo(adj_ramp_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_MAX_SPEED:
          max_speed_reg <= merge(max_speed_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_FEEDFORWARD_GAIN:
          feedforward_gain_reg <= merge_lo(feedforward_gain_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_P_GAIN:
          p_gain_reg <= merge_lo(p_gain_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_RATIO_MIN:
          ratio_min_reg <= merge_lo(ratio_min_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_RATIO_MAX:
          ratio_max_reg <= merge_lo(ratio_max_reg, w_data_reg, w_strb_reg);
        fsag_pkg::FSAG_OFS_CYCLE_MAX:
          cycle_max_reg <= merge_lo(cycle_max_reg, w_data_reg, w_strb_reg);
        default:
          homing_req_reg <= homing_req_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitors: encoder ratio and cycle watchdog

  logic [RATIO_W-1:0] line_cnt_reg;
  logic [RATIO_W-1:0] carr_cnt_reg;
  logic ratio_err_reg;
  logic [15:0] cyc_cnt_reg;
  logic cyc_run_reg;
  logic wdog_reg;

  // Counts carriage pulses per window of line pulses; judged on the window pulse
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      line_cnt_reg <= '0;
      carr_cnt_reg <= '0;
      ratio_err_reg <= 1'b0;
    end
    else if (RATIO_WINDOW)
    begin
      line_cnt_reg <= '0;
      carr_cnt_reg <= '0;
      ratio_err_reg <= (line_cnt_reg != '0) && ((carr_cnt_reg < RATIO_W'(ratio_min_reg))
                       || (carr_cnt_reg > RATIO_W'(ratio_max_reg)));
    end
    else
    begin
      if (LINE_PULSE && line_cnt_reg != '1)
      begin
        line_cnt_reg <= line_cnt_reg + 1'b1;
      end
      if (CARR_PULSE && carr_cnt_reg != '1)
      begin
        carr_cnt_reg <= carr_cnt_reg + 1'b1;
      end
    end
  end

  // Watchdog: each control cycle must restart before the limit runs out
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      cyc_cnt_reg <= 16'h0000;
      cyc_run_reg <= 1'b0;
      wdog_reg <= 1'b0;
    end
    else if (CYCLE_START)
    begin
      cyc_cnt_reg <= 16'h0000;
      cyc_run_reg <= 1'b1;
      wdog_reg <= 1'b0;
    end
    else if (cyc_run_reg)
    begin
      if (cyc_cnt_reg >= cycle_max_reg)
      begin
        wdog_reg <= 1'b1;
      end
      else
      begin
        cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error latch

  logic [7:0] code_next;
  logic hit_next;
  logic [7:0] code_reg;
  logic err_reg;
  logic hw_flag_reg;
  logic clear_any;
  fsag_pkg::fsag_state_e state_reg;

  // Fixed priority, lowest code wins; 08 and 16..30 are not produced
  always_comb
  begin
    hit_next = 1'b1;
    code_next = fsag_pkg::FSAG_ERR_PWR_LOW;
    if (FAULTS.pwr_low)
      code_next = fsag_pkg::FSAG_ERR_PWR_LOW;
    else if (FAULTS.cut_not_possible)
      code_next = fsag_pkg::FSAG_ERR_CUT_NP;
    else if (FAULTS.rear_limit && AUTO_CUTTING)
      code_next = fsag_pkg::FSAG_ERR_LIMIT;
    else if (FAULTS.mark_overflow)
      code_next = fsag_pkg::FSAG_ERR_MARK_OVF;
    else if (ratio_err_reg)
      code_next = fsag_pkg::FSAG_ERR_RATIO;
    else if (homing_req_reg && CUT_START && !HOMED)
      code_next = fsag_pkg::FSAG_ERR_NO_HOME;
    else if (FAULTS.seq_bad_state)
      code_next = fsag_pkg::FSAG_ERR_SEQ;
    else if (wdog_reg)
      code_next = fsag_pkg::FSAG_ERR_WDOG;
    else if (FAULTS.supply_bad != 5'b00000)
    begin
      code_next = fsag_pkg::FSAG_ERR_SUPPLY0;
      for (int i = fsag_pkg::FSAG_NUM_SUPPLY - 1; i >= 0; i--)
      begin
        if (FAULTS.supply_bad[i])
          code_next = fsag_pkg::FSAG_ERR_SUPPLY0 + 8'(i);
      end
    end
    else if (FAULTS.over_temp)
      code_next = fsag_pkg::FSAG_ERR_TEMP;
    else if (FAULTS.bus_fault)
      code_next = fsag_pkg::FSAG_ERR_BUS;
    else
      hit_next = 1'b0;
  end

  assign clear_any = clear_cmd || !LOOP_ENABLE;

  // A new fault in the clearing cycle still latches, so a standing cause re-arms at once
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      err_reg <= 1'b0;
      code_reg <= 8'h00;
    end
    else if (hit_next && (!err_reg || clear_any || code_reg == fsag_pkg::FSAG_ERR_PWR_LOW))
    begin
      err_reg <= 1'b1;
      code_reg <= code_next;
    end
    else if (err_reg && (clear_any || (code_reg == fsag_pkg::FSAG_ERR_PWR_LOW
             && !FAULTS.pwr_low)))
    begin
      err_reg <= 1'b0;
    end
  end

  // Hardware check failure is display only and survives every clear but reset
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      hw_flag_reg <= 1'b0;
    end
    else if (FAULTS.hw_fail)
    begin
      hw_flag_reg <= 1'b1;
    end
  end

  // Standstill only after the running cut ends
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_reg <= fsag_pkg::FSAG_RUN;
    end
    else
    begin
      case (state_reg)
        fsag_pkg::FSAG_RUN:
          if (err_reg)
            state_reg <= CUT_ACTIVE ? fsag_pkg::FSAG_CUT_FINISH : fsag_pkg::FSAG_HOLD;
        fsag_pkg::FSAG_CUT_FINISH:
          if (!err_reg)
            state_reg <= fsag_pkg::FSAG_RUN;
          else if (!CUT_ACTIVE)
            state_reg <= fsag_pkg::FSAG_HOLD;
        fsag_pkg::FSAG_HOLD:
          if (!err_reg)
            state_reg <= fsag_pkg::FSAG_RUN;
        default:
          state_reg <= fsag_pkg::FSAG_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Adjust mode gate and outputs

  logic adj_reg;
  logic [31:0] default_speed;

  // 10 percent of maximum; wide product so it cannot overflow
  assign default_speed = 32'((64'(max_speed_reg) * 64'(fsag_pkg::FSAG_ADJ_SPEED_PCT)) / 64'd100);

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      adj_reg <= 1'b0;
    end
    else if (adj_exit || (adj_reg && LOOP_ENABLE))
    begin
      adj_reg <= 1'b0;
    end
    else if (adj_req && !LOOP_ENABLE)
    begin
      adj_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      ERROR_OUT <= 1'b0;
      AXIS_HOLD <= 1'b0;
      ADJUST_MODE <= 1'b0;
      USE_SIM_LINE <= 1'b0;
      SIM_LINE_SPEED <= 32'h0000_0000;
      ACC_RAMP <= 16'h0000;
      DEC_RAMP <= 16'h0000;
      FEEDFORWARD_GAIN <= fsag_pkg::FSAG_RST_FEEDFORWARD_GAIN;
      P_GAIN <= fsag_pkg::FSAG_RST_P_GAIN;
    end
    else
    begin
      ERROR_OUT <= err_reg;
      AXIS_HOLD <= err_reg && state_reg == fsag_pkg::FSAG_HOLD;
      ADJUST_MODE <= adj_reg;
      USE_SIM_LINE <= adj_reg || SIM_LINE_SELECT;
      SIM_LINE_SPEED <= adj_speed_set_reg ? adj_speed_reg : default_speed;
      ACC_RAMP <= adj_reg ? adj_ramp_reg : 16'h0000;
      DEC_RAMP <= adj_reg ? adj_ramp_reg : 16'h0000;
      FEEDFORWARD_GAIN <= feedforward_gain_reg;
      P_GAIN <= p_gain_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[fsag_pkg::FSAG_ST_CODE_LSB +: 8] = hw_flag_reg && !err_reg
                                                  ? fsag_pkg::FSAG_ERR_HW : code_reg;
    status_word[fsag_pkg::FSAG_ST_ACTIVE] = err_reg;
    status_word[fsag_pkg::FSAG_ST_HOLD] = state_reg == fsag_pkg::FSAG_HOLD;
    status_word[fsag_pkg::FSAG_ST_ADJUST] = adj_reg;
    status_word[fsag_pkg::FSAG_ST_HW_FLAG] = hw_flag_reg;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR[7:0])
      fsag_pkg::FSAG_OFS_STATUS: rd_word = status_word;
      fsag_pkg::FSAG_OFS_CTRL: rd_word = {28'h000_0000, homing_req_reg, 3'b000};
      fsag_pkg::FSAG_OFS_ADJ_SPEED: rd_word = adj_speed_reg;
      fsag_pkg::FSAG_OFS_ADJ_RAMP: rd_word = {16'h0000, adj_ramp_reg};
      fsag_pkg::FSAG_OFS_MAX_SPEED: rd_word = max_speed_reg;
      fsag_pkg::FSAG_OFS_FEEDFORWARD_GAIN: rd_word = {16'h0000, feedforward_gain_reg};
      fsag_pkg::FSAG_OFS_P_GAIN: rd_word = {16'h0000, p_gain_reg};
      fsag_pkg::FSAG_OFS_RATIO_MIN: rd_word = {16'h0000, ratio_min_reg};
      fsag_pkg::FSAG_OFS_RATIO_MAX: rd_word = {16'h0000, ratio_max_reg};
      fsag_pkg::FSAG_OFS_CYCLE_MAX: rd_word = {16'h0000, cycle_max_reg};
      default:
      begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= fsag_pkg::FSAG_RESP_OKAY;
    end
    else
    begin
      // Ready whenever no answer is pending, never waiting for ARVALID to drop
      S_AXI_ARREADY <= !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_hit ? fsag_pkg::FSAG_RESP_OKAY : fsag_pkg::FSAG_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

//--- verif/fsag_machine.sv
// Machine-side partner: runs one cut of fixed length per request.
// Assumes requests arrive synchronous to CLK_SYS.
`timescale 1ns/1ps
module fsag_machine #(
  parameter int CUT_LEN = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cut_go,
  output logic cut_active
);
  int cnt_reg;
  always_ff @(posedge clk)
  begin
    if (rst || cnt_reg == 1)
      cnt_reg <= 0;
    else if (cut_go && cnt_reg == 0)
      cnt_reg <= CUT_LEN;
    else if (cnt_reg != 0)
      cnt_reg <= cnt_reg - 1;
  end
  assign cut_active = cnt_reg != 0;
endmodule

//--- verif/fsag_chk.sv
// Concurrent checks on the fault supervisor ports.
// Bound into fsag_top; one clock domain.
`timescale 1ns/1ps
module fsag_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire fsag_pkg::fsag_faults_s FAULTS,
  input wire logic LOOP_ENABLE,
  input wire logic AUTO_CUTTING,
  input wire logic CUT_ACTIVE,
  input wire logic CUT_START,
  input wire logic CYCLE_START,
  input wire logic RATIO_WINDOW,
  input wire logic ERROR_OUT,
  input wire logic AXIS_HOLD,
  input wire logic ADJUST_MODE,
  input wire logic USE_SIM_LINE,
  input wire logic [15:0] ACC_RAMP,
  input wire logic [15:0] DEC_RAMP
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic any_f;
  logic quiet;
  // Hardware flag excluded: it never raises the error output
  // Rear limit counts only during automatic cutting
  assign any_f = (FAULTS[11:0] & {2'b11, AUTO_CUTTING, 9'h1FF}) != 12'h000;
  assign quiet = !any_f && !CUT_START && !CYCLE_START && !RATIO_WINDOW;
  sequence s_stop_ready;
    any_f && LOOP_ENABLE && !CUT_ACTIVE && ERROR_OUT;
  endsequence
  a_err_set: assert property (any_f [*2] |-> ##1 ERROR_OUT)
    else $error("error output missing after fault");
  a_hold_after: assert property (s_stop_ready [*3] |-> AXIS_HOLD)
    else $error("axes not held after cut");
  a_cut_runs: assert property ((!AXIS_HOLD && CUT_ACTIVE) ##1 CUT_ACTIVE |-> !AXIS_HOLD)
    else $error("hold during running cut");
  a_err_clear: assert property ((!LOOP_ENABLE && quiet) [*3] |-> !ERROR_OUT)
    else $error("error kept with enable low");
  a_adj_gate: assert property ($rose(ADJUST_MODE) |-> !$past(LOOP_ENABLE, 2))
    else $error("adjust entered while enabled");
  a_adj_sim: assert property (ADJUST_MODE [*2] |-> USE_SIM_LINE)
    else $error("adjust without simulated line");
  a_ramp_same: assert property (ACC_RAMP == DEC_RAMP)
    else $error("ramps differ");
  a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read response dropped");
endmodule
bind fsag_top fsag_chk u_chk (.*);

//--- verif/tb_fsag_top.sv
// Self-checking bench for fsag_top with a machine partner.
// AXI4-Lite master tasks; bounded by a watchdog.
`timescale 1ns/1ps
module tb_fsag_top;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA, SIM_LINE_SPEED;
  fsag_pkg::fsag_faults_s FAULTS = '0;
  logic LOOP_ENABLE = 1, AUTO_CUTTING = 1, CUT_START = 0, HOMED = 0, CYCLE_START = 0;
  logic LINE_PULSE = 0, CARR_PULSE = 0, RATIO_WINDOW = 0, SIM_LINE_SELECT = 0;
  logic CUT_ACTIVE, ERROR_OUT, AXIS_HOLD, ADJUST_MODE, USE_SIM_LINE, cut_go = 0;
  logic [15:0] ACC_RAMP, DEC_RAMP, FEEDFORWARD_GAIN, P_GAIN;
  int n_fail = 0;
  int n_compared = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  fsag_top DUT (.*);
  fsag_machine u_mach (.clk(CLK_SYS), .rst(RST), .cut_go(cut_go), .cut_active(CUT_ACTIVE));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= {24'h00_0000, a};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge CLK_SYS);
      aw_done = aw_done || S_AXI_AWREADY;
      w_done = w_done || S_AXI_WREADY;
      S_AXI_AWVALID <= !aw_done;
      S_AXI_WVALID <= !w_done;
    end
    while (!S_AXI_BVALID) @(posedge CLK_SYS);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= {24'h00_0000, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    while (!S_AXI_RVALID) @(posedge CLK_SYS);
    d = {S_AXI_RDATA[31:2], S_AXI_RDATA[1:0]};
    S_AXI_RREADY <= 1'b0;
  endtask
  // Status low bits: hold flag skipped, active and code compared
  task automatic see(input logic [8:0] c);
    logic [31:0] r;
    rd(fsag_pkg::FSAG_OFS_STATUS, r);
    chk("status", {23'h00_0000, c}, {23'h00_0000, r[8:0]});
  endtask
  // Pulse line k: 0 cut start, 1 cycle start, 2 line, 3 carriage, 4 window
  task automatic pulse(input int k, input int n);
    {RATIO_WINDOW, CARR_PULSE, LINE_PULSE, CYCLE_START, CUT_START} <= 5'(1 << k);
    cyc(n);
    {RATIO_WINDOW, CARR_PULSE, LINE_PULSE, CYCLE_START, CUT_START} <= 5'h00;
    cyc(3);
  endtask
  task automatic drop_en();
    LOOP_ENABLE <= 1'b0;
    cyc(2);
    LOOP_ENABLE <= 1'b1;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_codes();
    logic [7:0] codes [12];
    codes = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h1F, 8'h07, 8'h04, 8'h03, 8'h02, 8'h01};
    for (int i = 0; i < 12; i++)
    begin
      FAULTS <= fsag_pkg::fsag_faults_s'(13'h0001 << i);
      cyc(3);
      chk("error_out", 1, ERROR_OUT);
      see({1'b1, codes[i]});
      wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0001);
      cyc(2);
      chk("error_kept", 1, ERROR_OUT);
      FAULTS <= '0;
      if (i % 2 == 0 && i < 11)
        wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0001);
      else if (i < 11)
        drop_en();
      cyc(3);
      chk("error_gone", 0, ERROR_OUT);
    end
  endtask
  task automatic t_hold();
    cut_go <= 1'b1;
    cyc(1);
    cut_go <= 1'b0;
    FAULTS.mark_overflow <= 1'b1;
    cyc(3);
    chk("hold_in_cut", 0, AXIS_HOLD);
    cyc(6);
    chk("hold_after", 1, AXIS_HOLD);
    FAULTS <= '0;
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0001);
    cyc(3);
    chk("hold_free", 0, AXIS_HOLD);
  endtask
  task automatic t_sources();
    AUTO_CUTTING <= 1'b0;
    FAULTS.rear_limit <= 1'b1;
    cyc(3);
    chk("limit_manual", 0, ERROR_OUT);
    FAULTS <= '0;
    AUTO_CUTTING <= 1'b1;
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0008);
    pulse(0, 1);
    see(9'h106);
    drop_en();
    wr(fsag_pkg::FSAG_OFS_CYCLE_MAX, 32'h0000_0005);
    pulse(1, 1);
    cyc(8);
    see(9'h109);
    // Park the watchdog far out so it stays quiet for the rest of the run
    wr(fsag_pkg::FSAG_OFS_CYCLE_MAX, 32'h0000_FFFF);
    pulse(1, 1);
    drop_en();
    wr(fsag_pkg::FSAG_OFS_RATIO_MAX, 32'h0000_0004);
    pulse(2, 1);
    pulse(3, 6);
    pulse(4, 1);
    see(9'h105);
    // An empty window withdraws the standing ratio verdict
    pulse(4, 1);
    drop_en();
    FAULTS.hw_fail <= 1'b1;
    cyc(4);
    chk("hw_quiet", 0, ERROR_OUT);
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0001);
    FAULTS <= '0;
    see(9'h000);
  endtask
  task automatic t_adjust();
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0002);
    cyc(2);
    chk("adj_refused", 0, ADJUST_MODE);
    LOOP_ENABLE <= 1'b0;
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0002);
    cyc(2);
    chk("adj_on", 1, ADJUST_MODE);
    chk("sim_line", 1, USE_SIM_LINE);
    chk("sim_speed", 32'h0000_2710 * 10 / 100, SIM_LINE_SPEED);
    chk("ramp", 1, {ACC_RAMP, DEC_RAMP} == 32'h0001_0001);
    wr(fsag_pkg::FSAG_OFS_CTRL, 32'h0000_0004);
    LOOP_ENABLE <= 1'b1;
    cyc(2);
    chk("adj_off", 0, ADJUST_MODE);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    cyc(6);
    RST <= 1'b0;
    cyc(1);
    chk("feedforward_gain", 32'h0000_2710, FEEDFORWARD_GAIN);
    chk("p_gain", 32'h0000_01F4, P_GAIN);
    wr(8'h28, 32'h0000_0000);
    chk("bad_wr", fsag_pkg::FSAG_RESP_SLVERR, S_AXI_BRESP);
    rd(8'h28, r);
    chk("bad_addr", fsag_pkg::FSAG_RESP_SLVERR, S_AXI_RRESP);
    t_codes();
    t_hold();
    t_sources();
    t_adjust();
    end_of_test();
  end
  // Whole sequence needs a few hundred cycles
  initial
  begin
    cyc(20000);
    n_fail++;
    end_of_test();
  end
endmodule
